// ===== verilog/gbx_pkg.sv
// shared constants, state encodings and decode helpers for the global
// bus arbiter and line exchange block; assumes one common cycle clock
package gbx_pkg;
	localparam int NUM_REQ = 8;
	localparam int WORD_W = 32;
	localparam int LINE_WORDS = 4;
	localparam int LINE_W = WORD_W * LINE_WORDS;
	localparam int FIFO_DEPTH = 8;
	// data word after the address cycle at which the hit line is read
	localparam logic [1:0] HIT_WORD = 2'h1;
	localparam logic [1:0] LAST_WORD = 2'h3;
	localparam logic [1:0] FIRST_WORD = 2'h0;
	localparam logic [NUM_REQ-1:0] GRANT_RST = 8'h00;
	localparam logic [NUM_REQ-1:0] PEND_RST = 8'h00;
	localparam logic [WORD_W-1:0] DATA_RST = 32'h00000000;

	// gray-coded along idle, request, address, data, wait
	typedef enum logic [2:0] {
		SND_IDLE = 3'h0,
		SND_REQ  = 3'h1,
		SND_ADDR = 3'h3,
		SND_DATA = 3'h2,
		SND_WAIT = 3'h6
	} gbx_snd_e;

	typedef enum logic [1:0] {
		RCV_IDLE = 2'h0,
		RCV_WAIT = 2'h1,
		RCV_TAKE = 2'h3
	} gbx_rcv_e;

	typedef enum logic {
		ARB_IDLE = 1'b0,
		ARB_BUSY = 1'b1
	} gbx_arb_e;

	// lowest set bit wins: index 0 has the highest priority
	function automatic logic [NUM_REQ-1:0] gbxFirstOne(
		input logic [NUM_REQ-1:0] v);
		gbxFirstOne = v & (~v + 8'h01);
	endfunction
endpackage

// ===== verilog/gbx_stream_if.sv
// valid/ready word stream between the exchange logic and its buffer
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface gbx_stream_if #(parameter int W = 32) ();
	logic         valid;
	logic         ready;
	logic [W-1:0] data;
	modport sink   (input valid, input data, output ready);
	modport source (output valid, output data, input ready);
endinterface

// ===== verilog/gbx_fifo.sv
// word fifo with a registered output stage holding the head word
// assumes DEPTH is a power of two; one clock, async active-low reset
`timescale 1ns/100ps
module gbx_fifo import gbx_pkg::*; #(
	parameter int W     = 32,
	parameter int DEPTH = 8,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst_n,
	// streams
	gbx_stream_if.sink     inS,
	gbx_stream_if.source   outS,
	// words held, memory plus output stage
	output logic [AW:0]    level
);
	logic [W-1:0]  mem [DEPTH];
	logic [AW-1:0] wrPtr_reg;
	logic [AW-1:0] rdPtr_reg;
	logic [AW:0]   count_reg;
	logic          outValid_reg;
	logic [W-1:0]  outData_reg;

	// handshake decode
	wire logic memEmpty = (count_reg == '0);
	wire logic doPush   = inS.valid && inS.ready;
	wire logic doPop    = !memEmpty && (!outValid_reg || outS.ready);
	wire logic [AW:0] count_next = count_reg + {{AW{1'b0}}, doPush}
		- {{AW{1'b0}}, doPop};

	assign inS.ready  = (count_reg != (AW+1)'(DEPTH));
	assign outS.valid = outValid_reg;
	assign outS.data  = outData_reg;
	assign level      = count_reg + {{AW{1'b0}}, outValid_reg};

	// storage has no reset, only pointers, count and output stage do
	always_ff @(posedge clk) begin
		if (doPush) begin
			mem[wrPtr_reg] <= inS.data;
		end
	end

	// pointers and count
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
			count_reg <= '0;
		end else begin
			wrPtr_reg <= wrPtr_reg + AW'(doPush);
			rdPtr_reg <= rdPtr_reg + AW'(doPop);
			count_reg <= count_next;
		end
	end

	// output stage refills whenever it empties or is taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			outValid_reg <= 1'b0;
			outData_reg  <= '0;
		end else begin
			if (doPop) begin
				outData_reg <= mem[rdPtr_reg];
			end
			outValid_reg <= doPop || (outValid_reg && !outS.ready);
		end
	end

	fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		count_reg <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule

// ===== verilog/gbx_arbiter.sv
// bus access control: latches requests while idle, then serves them
// in fixed priority; assumes requests are on the common cycle clock
`timescale 1ns/100ps
module gbx_arbiter import gbx_pkg::*; (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// one request and one grant per controller
	input  wire logic [NUM_REQ-1:0] reqLine,
	output logic      [NUM_REQ-1:0] grantLine
);
	gbx_arb_e           state_reg;
	gbx_arb_e           state_next;
	logic [NUM_REQ-1:0] pend_reg;
	logic [NUM_REQ-1:0] pend_next;
	logic [NUM_REQ-1:0] grant_reg;
	logic [NUM_REQ-1:0] grant_next;

	// owner release and what is left to serve
	wire logic               relDone = |(grant_reg & ~reqLine);
	wire logic [NUM_REQ-1:0] remain  = pend_reg & ~grant_reg;

	assign grantLine = grant_reg;

	// next state; new requests are ignored while busy
	always_comb begin
		state_next = state_reg;
		pend_next  = pend_reg;
		grant_next = grant_reg;
		unique case (state_reg)
			ARB_IDLE: begin
				pend_next = reqLine;
				if (|reqLine) begin
					grant_next = gbxFirstOne(reqLine);
					state_next = ARB_BUSY;
				end
			end
			ARB_BUSY: begin
				if (relDone) begin
					pend_next  = remain;
					grant_next = gbxFirstOne(remain);
					if (remain == '0) begin
						state_next = ARB_IDLE;
					end
				end
			end
		endcase
	end

	// state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ARB_IDLE;
			pend_reg  <= PEND_RST;
			grant_reg <= GRANT_RST;
		end else begin
			state_reg <= state_next;
			pend_reg  <= pend_next;
			grant_reg <= grant_next;
		end
	end

	grant_onehot_a: assert property (@(posedge clk) disable iff (!rst_n)
		$onehot0(grantLine))
		else $error("more than one grant");
	idle_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ARB_IDLE |=> pend_reg == $past(reqLine))
		else $error("idle arbiter did not latch requests");
	fast_grant_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ARB_IDLE && $onehot(reqLine)
		|=> grantLine == $past(reqLine))
		else $error("single request not granted next cycle");
	top_prio_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ARB_IDLE && reqLine[0] |=> grantLine[0])
		else $error("requester 0 not served first");
	busy_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ARB_BUSY && !relDone
		|=> $stable(pend_reg) && $stable(grantLine))
		else $error("busy arbiter changed its latched set");
	back_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg == ARB_BUSY && relDone && remain == '0
		|=> state_reg == ARB_IDLE && grantLine == '0)
		else $error("arbiter did not return to idle");
	reset_clear_a: assert property (@(posedge clk)
		!rst_n |-> grant_reg == '0 && pend_reg == '0)
		else $error("grant or latch not cleared in reset");
	two_req_c: cover property (@(posedge clk) disable iff (!rst_n)
		state_reg == ARB_IDLE && reqLine[0] && reqLine[1]
		##1 grantLine[0] ##[1:20] grantLine[1]);
endmodule

// ===== verilog/gbx_top.sv
// global bus arbiter plus this processor's remote line exchange engine
// assumes every global bus line is on the common cycle clock; the pins'
// wired levels are resolved outside from the output enables
//
// What this block does
// - every controller has its own request and grant line to the arbiter
// - the idle arbiter copies all request lines every cycle
// - any latched request makes it busy; it serves latched ones in order
// - once all latched requesters were granted it idles and latches again
// - fixed priority, index 0 highest, higher indices lower
// - from idle a lone request is granted in the next cycle
// - send and receive block the processor; an abort ends them only while waiting, never during a transfer
// - a receiving controller stalls its pipe and pulls receive-present low
// - a sender stalls, wins the bus, broadcasts address and line with send
// - a waiting receiver with equal address and buffer room for a whole line takes the line, pulls hit low
// - matched senders and receivers release the pipeline stall
// - each new receive-present edge makes waiting senders broadcast again
// - of several senders to one receiver only the first one succeeds
// - several receivers may take one line; sender cannot tell which
// - send is high with the address, in the first cycle after the grant
// - four 32-bit line words follow the address in consecutive cycles
// - the sender reads the hit line at the end of the second data word
// - at most one of the eight grants is high; only its owner drives
// - receive-present and hit are active-low wired-or lines, high if idle
`timescale 1ns/100ps
module gbx_top import gbx_pkg::*; #(
	parameter int CTRL_ID = 0,
	parameter int DEPTH   = FIFO_DEPTH,
	parameter int LVW     = $clog2(DEPTH) + 1
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// arbiter lines; slot CTRL_ID of extReqLine is unused
	input  wire logic [NUM_REQ-1:0] extReqLine,
	output logic      [NUM_REQ-1:0] arbGrantLine,
	// global data bus and send line
	input  wire logic [WORD_W-1:0]  busDataIn,
	output logic      [WORD_W-1:0]  busDataOut,
	output logic                    busDataOe,
	input  wire logic               sendIn,
	output logic                    sendOut,
	output logic                    sendOe,
	// open-drain receive-present and hit lines
	input  wire logic               recvPresentIn_n,
	output logic                    recvPresentOut_n,
	output logic                    recvPresentOe,
	input  wire logic               matchHitIn_n,
	output logic                    matchHitOut_n,
	output logic                    matchHitOe,
	// processor side
	input  wire logic               sendStart,
	input  wire logic               recvStart,
	input  wire logic [WORD_W-1:0]  opAddr,
	input  wire logic [LINE_W-1:0]  sendLine,
	input  wire logic               abortReq,
	output logic                    pipeStall,
	output logic                    sendDone,
	output logic                    recvDone,
	output logic                    opAborted,
	// received line words
	output logic      [WORD_W-1:0]  lineWord,
	output logic                    lineValid,
	input  wire logic               lineReady
);
	localparam int ROOM = DEPTH - LINE_WORDS;

	gbx_snd_e           sndState_reg;
	gbx_snd_e           sndState_next;
	gbx_rcv_e           rcvState_reg;
	gbx_rcv_e           rcvState_next;
	logic [1:0]         wordIdx_reg;
	logic [1:0]         wordIdx_next;
	logic [1:0]         takeIdx_reg;
	logic               hitSeen_reg;
	logic               rebc_reg;
	logic               recvPrev_reg;
	logic [WORD_W-1:0]  sndAddr_reg;
	logic [WORD_W-1:0]  rcvAddr_reg;
	logic [LINE_W-1:0]  line_reg;
	logic [WORD_W-1:0]  busData_reg;
	logic               busOe_reg;
	logic               send_reg;
	logic               sendDone_reg;
	logic               recvDone_reg;
	logic               aborted_reg;
	logic [NUM_REQ-1:0] arbReq;
	logic [LVW-1:0]     level;

	gbx_stream_if #(.W(WORD_W)) rxIn ();
	gbx_stream_if #(.W(WORD_W)) rxOut ();

	// own request line merged into the arbiter's slot
	wire logic ownGrant = arbGrantLine[CTRL_ID];
	wire logic lastWord = (wordIdx_reg == LAST_WORD);
	wire logic inData   = (sndState_reg == SND_DATA);
	// dropped in the last data cycle so the arbiter can move on
	wire logic ownReq = (sndState_reg == SND_REQ)
		|| (sndState_reg == SND_ADDR) || (inData && !lastWord);
	always_comb begin
		arbReq = extReqLine;
		arbReq[CTRL_ID] = ownReq;
	end

	// start and abort decode
	wire logic allIdle  = (sndState_reg == SND_IDLE)
		&& (rcvState_reg == RCV_IDLE);
	wire logic takeSend = allIdle && sendStart;
	// send has precedence when both starts arrive together
	wire logic takeRecv = allIdle && recvStart && !sendStart;
	// a new receiver shows only as a falling edge of the wired line;
	// a second receiver joining an already low line is not seen
	wire logic recvFall = recvPrev_reg && !recvPresentIn_n;
	// abort only while not owning the bus, so no transfer is cut short
	wire logic sndAbort = abortReq && ((sndState_reg == SND_WAIT)
		|| (sndState_reg == SND_REQ && !ownGrant));
	// receiver match: needs room for a whole line in the buffer
	wire logic haveRoom = (level <= LVW'(ROOM)) && rxIn.ready;
	wire logic rcvMatch = (rcvState_reg == RCV_WAIT) && sendIn
		&& (busDataIn == rcvAddr_reg) && haveRoom;
	wire logic rcvAbort = abortReq && (rcvState_reg == RCV_WAIT)
		&& !rcvMatch;
	wire logic takeLast = (rcvState_reg == RCV_TAKE)
		&& (takeIdx_reg == LAST_WORD);

	// sender next state
	always_comb begin
		sndState_next = sndState_reg;
		wordIdx_next  = wordIdx_reg;
		unique case (sndState_reg)
			SND_IDLE: begin
				if (takeSend) begin
					sndState_next = SND_REQ;
				end
			end
			SND_REQ: begin
				if (sndAbort) begin
					sndState_next = SND_IDLE;
				end else if (ownGrant) begin
					sndState_next = SND_ADDR;
				end
			end
			SND_ADDR: begin
				sndState_next = SND_DATA;
				wordIdx_next  = FIRST_WORD;
			end
			SND_DATA: begin
				wordIdx_next = wordIdx_reg + 2'h1;
				if (lastWord && hitSeen_reg) begin
					sndState_next = SND_IDLE;
				end else if (lastWord) begin
					sndState_next = (rebc_reg || recvFall)
						? SND_REQ : SND_WAIT;
				end
			end
			SND_WAIT: begin
				if (sndAbort) begin
					sndState_next = SND_IDLE;
				end else if (recvFall) begin
					sndState_next = SND_REQ;
				end
			end
			default: begin
				sndState_next = SND_IDLE;
			end
		endcase
	end

	// receiver next state
	always_comb begin
		rcvState_next = rcvState_reg;
		unique case (rcvState_reg)
			RCV_IDLE: begin
				if (takeRecv) begin
					rcvState_next = RCV_WAIT;
				end
			end
			RCV_WAIT: begin
				if (rcvMatch) begin
					rcvState_next = RCV_TAKE;
				end else if (rcvAbort) begin
					rcvState_next = RCV_IDLE;
				end
			end
			RCV_TAKE: begin
				if (takeLast) begin
					rcvState_next = RCV_IDLE;
				end
			end
			default: begin
				rcvState_next = RCV_IDLE;
			end
		endcase
	end

	// bus drive values, registered so the pins come from flip-flops
	wire logic nextAddr = (sndState_next == SND_ADDR);
	wire logic nextData = (sndState_next == SND_DATA);
	wire logic [WORD_W-1:0] nextWord
		= line_reg[wordIdx_next*WORD_W +: WORD_W];
	wire logic [WORD_W-1:0] busData_next = nextAddr ? sndAddr_reg
		: (nextData ? nextWord : DATA_RST);

	// sender and receiver state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sndState_reg <= SND_IDLE;
			rcvState_reg <= RCV_IDLE;
			wordIdx_reg  <= FIRST_WORD;
			takeIdx_reg  <= FIRST_WORD;
		end else begin
			sndState_reg <= sndState_next;
			rcvState_reg <= rcvState_next;
			wordIdx_reg  <= wordIdx_next;
			takeIdx_reg  <= (rcvState_reg == RCV_TAKE)
				? takeIdx_reg + 2'h1 : FIRST_WORD;
		end
	end

	// hit sampling and rebroadcast memory; an edge is kept only in address and data cycles, the clear in request wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hitSeen_reg  <= 1'b0;
			rebc_reg     <= 1'b0;
			recvPrev_reg <= 1'b1;
		end else begin
			recvPrev_reg <= recvPresentIn_n;
			if (sndState_reg == SND_ADDR) begin
				hitSeen_reg <= 1'b0;
			end else if (inData && wordIdx_reg == HIT_WORD) begin
				hitSeen_reg <= !matchHitIn_n;
			end
			if (recvFall && (sndState_reg == SND_ADDR || inData)) begin
				rebc_reg <= 1'b1;
			end else if (sndState_reg == SND_REQ) begin
				rebc_reg <= 1'b0;
			end
		end
	end

	// operands caught at instruction start
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sndAddr_reg <= DATA_RST;
			rcvAddr_reg <= DATA_RST;
			line_reg    <= '0;
		end else begin
			if (takeSend) begin
				sndAddr_reg <= opAddr;
				line_reg    <= sendLine;
			end
			if (takeRecv) begin
				rcvAddr_reg <= opAddr;
			end
		end
	end

	// bus pins and completion pulses
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busData_reg  <= DATA_RST;
			busOe_reg    <= 1'b0;
			send_reg     <= 1'b0;
			sendDone_reg <= 1'b0;
			recvDone_reg <= 1'b0;
			aborted_reg  <= 1'b0;
		end else begin
			busData_reg  <= busData_next;
			busOe_reg    <= nextAddr || nextData;
			send_reg     <= nextAddr;
			sendDone_reg <= inData && lastWord && hitSeen_reg;
			recvDone_reg <= takeLast;
			aborted_reg  <= sndAbort || rcvAbort;
		end
	end

	// received words go straight into the buffer
	assign rxIn.valid  = (rcvState_reg == RCV_TAKE);
	assign rxIn.data   = busDataIn;
	assign rxOut.ready = lineReady;
	assign lineWord    = rxOut.data;
	assign lineValid   = rxOut.valid;

	// outputs; wired lines only ever pull low
	assign busDataOut       = busData_reg;
	assign busDataOe        = busOe_reg;
	assign sendOut          = send_reg;
	assign sendOe           = busOe_reg;
	assign recvPresentOut_n = 1'b0;
	assign recvPresentOe    = (rcvState_reg == RCV_WAIT);
	assign matchHitOut_n    = 1'b0;
	assign matchHitOe       = (rcvState_reg == RCV_TAKE);
	assign pipeStall        = !allIdle;
	assign sendDone         = sendDone_reg;
	assign recvDone         = recvDone_reg;
	assign opAborted        = aborted_reg;

	gbx_arbiter u_arb (
		.clk       (clk),
		.rst_n     (rst_n),
		.reqLine   (arbReq),
		.grantLine (arbGrantLine)
	);

	gbx_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_rxq (
		.clk   (clk),
		.rst_n (rst_n),
		.inS   (rxIn),
		.outS  (rxOut),
		.level (level)
	);

	drive_owner_a: assert property (@(posedge clk) disable iff (!rst_n)
		busDataOe |-> $past(ownGrant))
		else $error("bus driven without grant");
	addr_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
		sndState_reg == SND_REQ && ownGrant && !abortReq
		|=> sendOut && busDataOe && busDataOut == sndAddr_reg)
		else $error("address cycle not right after grant");
	four_words_a: assert property (@(posedge clk) disable iff (!rst_n)
		sndState_reg == SND_ADDR
		|=> (busDataOe && !sendOut)[*4])
		else $error("line words not in four consecutive cycles");
	hit_sample_a: assert property (@(posedge clk) disable iff (!rst_n)
		inData && wordIdx_reg == HIT_WORD
		|=> hitSeen_reg == !$past(matchHitIn_n))
		else $error("hit line not sampled at second word");
	send_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
		inData && lastWord && hitSeen_reg
		|=> sendDone && sndState_reg == SND_IDLE)
		else $error("matched sender kept stalling");
	rebroadcast_a: assert property (@(posedge clk) disable iff (!rst_n)
		sndState_reg == SND_WAIT && recvFall && !abortReq
		|=> sndState_reg == SND_REQ ##1 ownReq)
		else $error("waiting sender ignored new receiver");
	recv_present_a: assert property (@(posedge clk) disable iff (!rst_n)
		rcvState_reg == RCV_WAIT |-> recvPresentOe && pipeStall)
		else $error("receiver not announced or not stalled");
	recv_take_a: assert property (@(posedge clk) disable iff (!rst_n)
		rcvMatch |=> matchHitOe[*4] ##1 recvDone)
		else $error("matched receiver did not take four words");
	abort_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
		sndState_reg == SND_WAIT && abortReq
		|=> opAborted && sndState_reg == SND_IDLE)
		else $error("abort did not end blocked send");
	send_ok_c: cover property (@(posedge clk) disable iff (!rst_n)
		sndState_reg == SND_REQ ##[1:20] sendDone);
	resend_c: cover property (@(posedge clk) disable iff (!rst_n)
		sndState_reg == SND_WAIT ##[1:50] sendDone);
	recv_ok_c: cover property (@(posedge clk) disable iff (!rst_n)
		rcvState_reg == RCV_WAIT ##[1:50] recvDone);
endmodule

// ===== tb/gbx_peer_model.sv
// far-side controller: one sender and one receiver on the global bus
// assumes the bench resolves shared and wired lines from these drives
`timescale 1ns/100ps
module gbx_peer_model import gbx_pkg::*; #(
	parameter int SLOT = 3
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// global bus as seen here
	input  wire logic [NUM_REQ-1:0] grantLine,
	input  wire logic [WORD_W-1:0]  busDataIn,
	input  wire logic               sendIn,
	output logic                    req,
	output logic      [WORD_W-1:0]  dataOut,
	output logic                    dataOe,
	output logic                    sendOut,
	output logic                    presPull,
	output logic                    hitPull,
	// commands from the bench
	input  wire logic               doSend,
	input  wire logic [WORD_W-1:0]  txAddr,
	input  wire logic [LINE_W-1:0]  txLine,
	input  wire logic               rxArm,
	input  wire logic [WORD_W-1:0]  rxAddr
);
	logic [2:0] cnt_reg;
	logic [2:0] hitCnt_reg;
	logic       got_reg;
	logic [1:0] wordIdx;
	logic       match;

	// 0 idle, 1 requesting, 2 address, 3..6 line words
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			cnt_reg <= 3'h0;
		else if (cnt_reg == 3'h0)
			cnt_reg <= doSend ? 3'h1 : 3'h0;
		else if (cnt_reg == 3'h1)
			cnt_reg <= grantLine[SLOT] ? 3'h2 : 3'h1;
		else
			cnt_reg <= (cnt_reg == 3'h6) ? 3'h0 : cnt_reg + 3'h1;
	end

	// request falls in the final word cycle to hand the bus back
	assign req = (cnt_reg != 3'h0) && (cnt_reg != 3'h6);
	assign dataOe = cnt_reg >= 3'h2;
	assign sendOut = cnt_reg == 3'h2;
	assign wordIdx = cnt_reg[1:0] - 2'h3;
	assign dataOut = sendOut ? txAddr : txLine[wordIdx*WORD_W +: WORD_W];

	// receiver: one match per arming, hit held over the four words
	assign match = rxArm && !got_reg && sendIn && busDataIn == rxAddr;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			got_reg    <= 1'b0;
			hitCnt_reg <= 3'h0;
		end else begin
			got_reg    <= rxArm && (got_reg || match);
			hitCnt_reg <= match ? 3'h4 :
				(hitCnt_reg != 3'h0) ? hitCnt_reg - 3'h1 : 3'h0;
		end
	end
	assign presPull = rxArm && !got_reg;
	assign hitPull = hitCnt_reg != 3'h0;
endmodule

// ===== tb/tb_top.sv
// bench for the arbiter and line exchange top with one peer controller
// assumes the peer sits in arbiter slot 3 and the own engine in slot 0
`timescale 1ns/100ps
module tb_top import gbx_pkg::*; ();
	logic clk = 1'b0, rst_n = 1'b1;
	logic [NUM_REQ-1:0] tbReq = '0, extReqLine, arbGrantLine;
	logic [WORD_W-1:0] busDataIn, busDataOut, pData, lineWord;
	logic [WORD_W-1:0] idlePat = 32'h5A5A5A5A, opAddr = '0, txAddr = '0;
	logic [WORD_W-1:0] rxAddr = '0;
	logic [LINE_W-1:0] sendLine = '0, txLine = '0;
	logic busDataOe, sendIn, sendOut, sendOe, recvPresentIn_n;
	logic recvPresentOut_n, recvPresentOe, matchHitIn_n, matchHitOut_n;
	logic matchHitOe, pipeStall, sendDone, recvDone, opAborted, lineValid;
	logic sendStart = 1'b0, recvStart = 1'b0, abortReq = 1'b0;
	logic lineReady = 1'b0, doSend = 1'b0, rxArm = 1'b0;
	logic pReq, pOe, pSend, pPres, pHit;
	int n_fail = 0, check_count = 0;

	always #5 clk = ~clk;
	// released bus shows a changing pattern, never the last value
	always @(posedge clk) idlePat <= ~idlePat;
	assign busDataIn = busDataOe ? busDataOut : pOe ? pData : idlePat;
	assign sendIn = (sendOe & sendOut) | (pOe & pSend);
	assign recvPresentIn_n = ~((recvPresentOe & ~recvPresentOut_n) | pPres);
	assign matchHitIn_n = ~((matchHitOe & ~matchHitOut_n) | pHit);
	assign extReqLine = tbReq | {4'h0, pReq, 3'h0};

	gbx_top gbx_top_i (.clk, .rst_n, .extReqLine, .arbGrantLine,
		.busDataIn, .busDataOut, .busDataOe, .sendIn, .sendOut, .sendOe,
		.recvPresentIn_n, .recvPresentOut_n, .recvPresentOe,
		.matchHitIn_n, .matchHitOut_n, .matchHitOe, .sendStart, .recvStart,
		.opAddr, .sendLine, .abortReq, .pipeStall, .sendDone, .recvDone,
		.opAborted, .lineWord, .lineValid, .lineReady);
	gbx_peer_model gbx_peer_model_i (.clk, .rst_n, .grantLine(arbGrantLine),
		.busDataIn, .sendIn, .req(pReq), .dataOut(pData), .dataOe(pOe),
		.sendOut(pSend), .presPull(pPres), .hitPull(pHit), .doSend, .txAddr,
		.txLine, .rxArm, .rxAddr);

	task automatic cyc(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic t_prio();
		tbReq = 8'h62;
		cyc();
		chk("first", arbGrantLine, 8'h02);
		tbReq = 8'h64; // slot 2 rises while busy
		cyc();
		chk("second", arbGrantLine, 8'h20);
		tbReq[5] = 1'b0;
		cyc();
		chk("third", arbGrantLine, 8'h40);
		tbReq[6] = 1'b0;
		cyc();
		chk("idle", arbGrantLine, 8'h00);
		cyc();
		chk("relatch", arbGrantLine, 8'h04);
		tbReq[2] = 1'b0;
		cyc();
		chk("free", arbGrantLine, 8'h00);
	endtask
	task automatic bcast(input logic [31:0] a);
		for (int k = 0; k < 40 && arbGrantLine[0] !== 1'b1; k++)
			cyc();
		chk("own grant", arbGrantLine, 8'h01);
		cyc();
		chk("send", {sendOut, busDataOe, sendOe}, 3'b111);
		chk("addr", busDataOut, a);
		for (int i = 1; i <= 4; i++) begin
			cyc();
			chk("word", busDataOut, a + i);
		end
	endtask
	task automatic t_send(input logic [31:0] a, input bit hit);
		opAddr = a;
		sendLine = {a + 32'h4, a + 32'h3, a + 32'h2, a + 32'h1};
		sendStart = 1'b1;
		cyc();
		sendStart = 1'b0;
		chk("stall", pipeStall, 1);
		bcast(a);
		cyc();
		chk("sdone", sendDone, hit);
		chk("sstall", pipeStall, !hit);
	endtask
	task automatic t_late(input logic [31:0] a);
		opAddr = a;
		sendLine = {a + 32'h4, a + 32'h3, a + 32'h2, a + 32'h1};
		sendStart = 1'b1;
		cyc();
		sendStart = 1'b0;
		for (int k = 0; k < 40 && arbGrantLine[0] !== 1'b1; k++)
			cyc();
		cyc(2);
		// receiver turns up after the address cycle, in word 0
		rxAddr = a;
		rxArm = 1'b1;
		cyc(4);
		chk("late miss", sendDone, 0);
		bcast(a);
		cyc();
		chk("late", sendDone, 1);
		rxArm = 1'b0;
	endtask
	task automatic abort_op();
		abortReq = 1'b1;
		cyc();
		abortReq = 1'b0;
		for (int k = 0; k < 3 && opAborted !== 1'b1; k++)
			cyc();
		chk("aborted", opAborted, 1);
		cyc();
		chk("unstall", pipeStall, 0);
	endtask
	task automatic peer_tx(input logic [31:0] a, input bit hit);
		txAddr = a;
		txLine = {a + 32'h4, a + 32'h3, a + 32'h2, a + 32'h1};
		doSend = 1'b1;
		cyc();
		doSend = 1'b0;
		for (int k = 0; k < 40 && pSend !== 1'b1; k++)
			cyc();
		repeat (4) begin
			cyc();
			chk("hit", {matchHitOe, matchHitOut_n}, {hit, 1'b0});
		end
		cyc();
		chk("rdone", recvDone, hit);
		chk("rstall", pipeStall, !hit);
	endtask
	task automatic t_fifo();
		logic [31:0] e;
		for (int r = 0; r < 3; r++) begin
			opAddr = {r[23:0] + 24'h1, 8'h00};
			recvStart = 1'b1;
			cyc();
			recvStart = 1'b0;
			chk("present", {recvPresentOe, pipeStall, recvPresentOut_n},
				3'b110);
			if (r == 0)
				peer_tx(opAddr ^ 32'h10, 0);
			peer_tx(opAddr, r < 2);
		end
		abort_op();
		lineReady = 1'b1;
		for (int i = 0; i < 8; i++) begin
			e = {i[25:2] + 24'h1, 6'h00, i[1:0]} + 32'h1;
			chk("lvalid", lineValid, 1);
			chk("line", lineWord, e);
			cyc();
		end
		chk("empty", lineValid, 0);
	endtask

	// watchdog far beyond the hundred or so cycles the run needs
	initial begin
		#50000;
		n_fail++;
		print_verdict();
	end
	initial begin
		// a real falling edge, so the async reset acts before any clock
		#1 rst_n = 1'b0;
		cyc(6);
		rst_n = 1'b1;
		chk("reset", {arbGrantLine, busDataOe, recvPresentOe, pipeStall}, 0);
		chk("reset pulses", {lineValid, sendOut, opAborted, sendDone}, 0);
		tbReq[2] = 1'b1;
		cyc();
		chk("lone", arbGrantLine, 8'h04);
		tbReq[2] = 1'b0;
		cyc();
		chk("drop", arbGrantLine, 8'h00);
		t_prio();
		rxAddr = 32'h40;
		rxArm = 1'b1;
		t_send(32'h40, 1);
		rxArm = 1'b0;
		t_send(32'h80, 0);
		rxAddr = 32'h80;
		rxArm = 1'b1;
		bcast(32'h80);
		cyc();
		chk("rebroadcast", sendDone, 1);
		rxArm = 1'b0;
		t_late(32'h140);
		t_send(32'hC0, 0);
		abort_op();
		t_fifo();
		print_verdict();
	end
endmodule
